//--- shared/mpgt_pkg.sv
// Purpose: Constants and types for the monitor pin and supply-good timing block
// Assumes: 100 MHz pclk, APB register access
// Notes: Delay figures are in milliseconds; cycle counts derive from the clock rate

package mpgt_pkg;

    // ****************************************
    // Clock and time base
    // ****************************************
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OFS_CONFIG = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_INT_STATUS = 12'h008;
    localparam logic [11:0] OFS_INT_MASK = 12'h00C;
    localparam int CFG_P4_LSB = 0;
    localparam int CFG_P5_LSB = 4;
    localparam int CFG_POL = 7;
    localparam int CFG_SRC = 8;
    localparam int CFG_DEB_LSB = 9;
    localparam int CFG_ON_LSB = 11;
    localparam int CFG_OFF_LSB = 13;
    localparam logic [14:0] CFG_RESET = 15'h0000;
    localparam int INT_W = 7;
    localparam logic [6:0] MASK_RESET = 7'h00;
    localparam int INT_GOOD_RISE = 0;
    localparam int INT_GOOD_FALL = 1;
    localparam int INT_P4_OV = 2;
    localparam int INT_P4_UV = 3;
    localparam int INT_P5_OV = 4;
    localparam int INT_P5_UV = 5;
    localparam int INT_MAINS_FALL = 6;

    // ****************************************
    // Monitor pin function codes
    // ****************************************
    localparam logic [2:0] FN_GOOD_A = 3'h0;
    localparam logic [2:0] FN_GOOD_B = 3'h1;
    localparam logic [2:0] FN_POS_OV = 3'h2;
    localparam logic [2:0] FN_POS_UV = 3'h3;
    localparam logic [2:0] FN_NEG_OV = 3'h4;
    localparam logic [2:0] FN_NEG_UV = 3'h5;
    localparam logic [2:0] FN_FLAG = 3'h6;
    localparam logic [2:0] FN_FLAG_INV = 3'h7;

    // ****************************************
    // Delay tables in milliseconds
    // ****************************************
    localparam int unsigned DEB_MS_0 = 80;
    localparam int unsigned DEB_MS_1 = 0;
    localparam int unsigned DEB_MS_2 = 40;
    localparam int unsigned DEB_MS_3 = 160;
    localparam int unsigned ON_MS_0 = 400;
    localparam int unsigned ON_MS_1 = 200;
    localparam int unsigned ON_MS_2 = 800;
    localparam int unsigned ON_MS_3 = 1600;
    localparam int unsigned OFF_MS_0 = 2;
    localparam int unsigned OFF_MS_1 = 2;
    localparam int unsigned OFF_MS_2 = 1;
    localparam int unsigned OFF_MS_3 = 4;

    // ****************************************
    // Synchronised input positions
    // ****************************************
    localparam int IN_W = 7;
    localparam int IN_LOW = 0;
    localparam int IN_MID = 1;
    localparam int IN_HIGH = 2;
    localparam int IN_DAC = 3;
    localparam int IN_MS1 = 4;
    localparam int IN_MS2 = 5;
    localparam int IN_REQ = 6;

    typedef enum logic [1:0] {
        MPGT_OFF,
        MPGT_ON_WAIT,
        MPGT_GOOD,
        MPGT_OFF_WAIT
    } mpgt_seq_t;

endpackage : mpgt_pkg

//--- rtl/mpgt_top.sv
// Purpose: Monitor pins four and five, mains-good select, request debounce, supply-good timing
// Assumes: Comparator results arrive as asynchronous digital levels
// Notes: All state sits in one packed struct; APB slave with no wait states
//
// How it works
// - Positive overvoltage on pin four sets flag and overvoltage above 1.25 V, clears both below 1.15 V.
// - Positive undervoltage on pin four raises undervoltage below 1.25 V, sets flag above 1.35 V.
// - Negative overvoltage on pin four raises overvoltage below 1.25 V, sets flag above 1.35 V.
// - Negative undervoltage on pin four clears both below 1.15 V, sets both above 1.25 V.
// - Pin four as supply-good output uses the shared good-output polarity bit.
// - Pin five codes 000 and 001 drive mains-good with the shared polarity bit.
// - Pin five codes 010 to 110 compare against the DAC level, code 111 enables the reference.
// - The source select picks mains-good from sense one when clear, sense two when set.
// - Supply-good asserts 400, 200, 800 or 1600 ms after power enable rises.
// - Power enable drops 2, 2, 1 or 4 ms after the request takes supply-good away.

`timescale 1ns/1ns
`default_nettype none

module mpgt_top
    import mpgt_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_on_request,
    input wire logic mains_sense_one,
    input wire logic mains_sense_two,
    input wire logic pin_four_above_low,
    input wire logic pin_four_above_mid,
    input wire logic pin_four_above_high,
    input wire logic pin_five_above_dac,
    output logic monitor_pin_four,
    output logic monitor_pin_five,
    output logic reference_out_en,
    output logic pin_four_ov,
    output logic pin_four_uv,
    output logic pin_five_ov,
    output logic pin_five_uv,
    output logic supply_good_out,
    output logic mains_good_out,
    output logic power_enable,
    output logic irq
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [IN_W-1:0] sync1;
        logic [IN_W-1:0] sync2;
        logic [14:0] cfg;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic hyst_lo;
        logic hyst_hi;
        logic req_deb;
        logic [31:0] deb_cnt;
        logic [31:0] seq_cnt;
        mpgt_seq_t seq;
        logic good;
        logic pen;
        logic mains;
        logic flag4;
        logic ov4;
        logic uv4;
        logic flag5;
        logic ov5;
        logic uv5;
        logic pin4;
        logic pin5;
        logic ref_en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mpgt_state_t;

    mpgt_state_t cur;
    mpgt_state_t next_cur;
    logic [2:0] r4;
    logic [2:0] r5;
    logic [31:0] deb_target;
    logic [31:0] on_target;
    logic [31:0] off_target;

    // ****************************************
    // Helpers
    // ****************************************
    // Returns {flag, ov, uv} for a comparator mode
    function automatic logic [2:0] mpgt_decode(
        input logic [2:0] code,
        input logic lo,
        input logic hi
    );
        logic [2:0] r;
        r = 3'h0;
        unique case (code)
            FN_POS_OV: r = {lo, lo, 1'b0};
            FN_POS_UV: r = {hi, 1'b0, ~hi};
            FN_NEG_OV: r = {hi, ~hi, 1'b0};
            FN_NEG_UV: r = {lo, 1'b0, lo};
            FN_FLAG: r = {lo, 1'b0, 1'b0};
            FN_FLAG_INV: r = {~lo, 1'b0, 1'b0};
            FN_GOOD_A, FN_GOOD_B: r = 3'h0;
        endcase
        return r;
    endfunction : mpgt_decode

    function automatic logic [31:0] mpgt_cycles(
        input int unsigned ms
    );
        return 32'(ms * CYCLES_PER_MS);
    endfunction : mpgt_cycles

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [2:0] p4_func;
        logic [2:0] p5_func;
        logic pol;
        logic [INT_W-1:0] ev;
        logic [INT_W-1:0] clr;
        logic setup;
        logic access;
        next_cur = cur;
        p4_func = cur.cfg[CFG_P4_LSB +: 3];
        p5_func = cur.cfg[CFG_P5_LSB +: 3];
        pol = cur.cfg[CFG_POL];
        ev = '0;
        clr = '0;
        setup = psel & ~penable;
        access = psel & penable & cur.pready;

        // Two-stage synchroniser for all asynchronous levels
        next_cur.sync1 = {power_on_request, mains_sense_two, mains_sense_one,
                          pin_five_above_dac, pin_four_above_high,
                          pin_four_above_mid, pin_four_above_low};
        next_cur.sync2 = cur.sync1;

        // Hysteresis: 1.15/1.25 V band and 1.25/1.35 V band
        next_cur.hyst_lo = cur.sync2[IN_MID] | (cur.hyst_lo & cur.sync2[IN_LOW]);
        next_cur.hyst_hi = cur.sync2[IN_HIGH] | (cur.hyst_hi & cur.sync2[IN_MID]);

        next_cur.mains = cur.cfg[CFG_SRC] ? cur.sync2[IN_MS2] : cur.sync2[IN_MS1];

        // ****************************************
        // Monitor pin four
        // ****************************************
        r4 = mpgt_decode(p4_func, next_cur.hyst_lo, next_cur.hyst_hi);
        next_cur.flag4 = r4[2];
        next_cur.ov4 = r4[1];
        next_cur.uv4 = r4[0];
        next_cur.pin4 = r4[2];

        // ****************************************
        // Monitor pin five
        // ****************************************
        // DAC comparison, single threshold
        r5 = mpgt_decode(p5_func, cur.sync2[IN_DAC], cur.sync2[IN_DAC]);
        next_cur.ref_en = 1'b0;
        next_cur.flag5 = r5[2];
        next_cur.ov5 = r5[1];
        next_cur.uv5 = r5[0];
        unique case (p5_func)
            FN_GOOD_A, FN_GOOD_B: begin
                next_cur.pin5 = next_cur.mains ^ pol;
            end
            FN_FLAG_INV: begin
                next_cur.ref_en = 1'b1;
                next_cur.pin5 = 1'b0;
                next_cur.flag5 = 1'b0;
                next_cur.ov5 = 1'b0;
                next_cur.uv5 = 1'b0;
            end
            FN_POS_OV, FN_POS_UV, FN_NEG_OV, FN_NEG_UV, FN_FLAG: begin
                next_cur.pin5 = r5[2];
            end
        endcase

        // ****************************************
        // Delay selection
        // ****************************************
        // debounce table
        unique case (cur.cfg[CFG_DEB_LSB +: 2])
            2'h0: deb_target = mpgt_cycles(DEB_MS_0);
            2'h1: deb_target = mpgt_cycles(DEB_MS_1);
            2'h2: deb_target = mpgt_cycles(DEB_MS_2);
            2'h3: deb_target = mpgt_cycles(DEB_MS_3);
        endcase
        unique case (cur.cfg[CFG_ON_LSB +: 2])
            2'h0: on_target = mpgt_cycles(ON_MS_0);
            2'h1: on_target = mpgt_cycles(ON_MS_1);
            2'h2: on_target = mpgt_cycles(ON_MS_2);
            2'h3: on_target = mpgt_cycles(ON_MS_3);
        endcase
        unique case (cur.cfg[CFG_OFF_LSB +: 2])
            2'h0: off_target = mpgt_cycles(OFF_MS_0);
            2'h1: off_target = mpgt_cycles(OFF_MS_1);
            2'h2: off_target = mpgt_cycles(OFF_MS_2);
            2'h3: off_target = mpgt_cycles(OFF_MS_3);
        endcase

        // ****************************************
        // Request debounce
        // ****************************************
        // level must differ for the whole delay
        if (cur.sync2[IN_REQ] == cur.req_deb) begin
            next_cur.deb_cnt = '0;
        end else if (cur.deb_cnt + 32'h1 >= deb_target) begin
            next_cur.req_deb = cur.sync2[IN_REQ];
            next_cur.deb_cnt = '0;
        end else begin
            next_cur.deb_cnt = cur.deb_cnt + 32'h1;
        end

        // ****************************************
        // Power sequencer
        // ****************************************
        unique case (cur.seq)
            MPGT_OFF: begin
                if (cur.req_deb) begin
                    next_cur.seq = MPGT_ON_WAIT;
                    next_cur.pen = 1'b1;
                    next_cur.seq_cnt = '0;
                end
            end
            MPGT_ON_WAIT: begin
                if (!cur.req_deb) begin
                    next_cur.seq = MPGT_OFF_WAIT;
                    next_cur.seq_cnt = '0;
                end else if (cur.seq_cnt + 32'h1 >= on_target) begin
                    next_cur.seq = MPGT_GOOD;
                    next_cur.good = 1'b1;
                end else begin
                    next_cur.seq_cnt = cur.seq_cnt + 32'h1;
                end
            end
            MPGT_GOOD: begin
                if (!cur.req_deb) begin
                    next_cur.seq = MPGT_OFF_WAIT;
                    next_cur.good = 1'b0;
                    next_cur.seq_cnt = '0;
                end
            end
            MPGT_OFF_WAIT: begin
                if (cur.seq_cnt + 32'h1 >= off_target) begin
                    next_cur.seq = MPGT_OFF;
                    next_cur.pen = 1'b0;
                end else begin
                    next_cur.seq_cnt = cur.seq_cnt + 32'h1;
                end
            end
        endcase
        if (p4_func == FN_GOOD_A || p4_func == FN_GOOD_B) begin
            next_cur.pin4 = next_cur.good ^ pol;
        end

        // ****************************************
        // Interrupt events
        // ****************************************
        ev[INT_GOOD_RISE] = next_cur.good & ~cur.good;
        ev[INT_GOOD_FALL] = ~next_cur.good & cur.good;
        ev[INT_P4_OV] = next_cur.ov4 & ~cur.ov4;
        ev[INT_P4_UV] = next_cur.uv4 & ~cur.uv4;
        ev[INT_P5_OV] = next_cur.ov5 & ~cur.ov5;
        ev[INT_P5_UV] = next_cur.uv5 & ~cur.uv5;
        ev[INT_MAINS_FALL] = ~next_cur.mains & cur.mains;

        // ****************************************
        // APB slave
        // ****************************************
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;
        if (setup) begin
            next_cur.pready = 1'b1;
            next_cur.prdata = '0;
            unique case (paddr)
                OFS_CONFIG: next_cur.prdata = {17'h00000, cur.cfg};
                OFS_STATUS: begin
                    next_cur.prdata = {20'h00000, cur.seq, cur.req_deb,
                                       cur.uv5, cur.ov5, cur.flag5,
                                       cur.uv4, cur.ov4, cur.flag4,
                                       cur.mains, cur.pen, cur.good};
                end
                OFS_INT_STATUS: next_cur.prdata = {25'h0000000, cur.int_stat};
                OFS_INT_MASK: next_cur.prdata = {25'h0000000, cur.int_mask};
                default: next_cur.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite && !cur.pslverr) begin
            if (paddr == OFS_CONFIG) begin
                next_cur.cfg = pwdata[14:0];
            end
            if (paddr == OFS_INT_MASK) begin
                next_cur.int_mask = pwdata[INT_W-1:0];
            end
        end
        // Clear only what the read returned; a new event wins
        if (access && !pwrite && paddr == OFS_INT_STATUS) begin
            clr = cur.prdata[INT_W-1:0];
        end
        next_cur.int_stat = (cur.int_stat & ~clr) | ev;
        next_cur.irq = |(next_cur.int_stat & next_cur.int_mask);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.cfg <= CFG_RESET;
            cur.int_mask <= MASK_RESET;
            cur.seq <= MPGT_OFF;
        end else begin
            cur <= next_cur;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign monitor_pin_four = cur.pin4;
    assign monitor_pin_five = cur.pin5;
    assign reference_out_en = cur.ref_en;
    assign pin_four_ov = cur.ov4;
    assign pin_four_uv = cur.uv4;
    assign pin_five_ov = cur.ov5;
    assign pin_five_uv = cur.uv5;
    assign supply_good_out = cur.good;
    assign mains_good_out = cur.mains;
    assign power_enable = cur.pen;
    assign irq = cur.irq;

endmodule : mpgt_top

`default_nettype wire

//--- tb/mpgt_chk_sva.sv
// Purpose: Port-level checks for mpgt_top
// Assumes: Bound to every mpgt_top instance
// Notes: Delay windows span every delay code
`timescale 1ns/1ns
`default_nettype none
module mpgt_chk
    import mpgt_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic monitor_pin_five,
    input wire logic reference_out_en,
    input wire logic pin_four_ov,
    input wire logic pin_four_uv,
    input wire logic pin_five_ov,
    input wire logic pin_five_uv,
    input wire logic supply_good_out,
    input wire logic power_enable
);
    int unsigned cnt;
    logic good_q;
    logic pen_q;
    logic had_good;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****
    // Cycles since good or enable last moved
    // ****
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            good_q <= 1'h0;
            pen_q <= 1'h0;
            had_good <= 1'h0;
        end else begin
            if (supply_good_out != good_q || power_enable != pen_q) begin
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
            good_q <= supply_good_out;
            pen_q <= power_enable;
            had_good <= supply_good_out | (had_good & power_enable);
        end
    end
    // ****
    // Properties
    // ****
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    chk_setup_answer: assert property (s_setup |=> s_access)
        else $error("no answer after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_unmapped: assert property ((s_setup and (paddr[11:4] != 8'h00)) |=> pslverr)
        else $error("unmapped access without error");
    chk_ref_quiet: assert property (
        reference_out_en |-> !monitor_pin_five && !pin_five_ov && !pin_five_uv)
        else $error("reference mode with flags");
    chk_ovuv_excl: assert property (
        !(pin_four_ov && pin_four_uv) && !(pin_five_ov && pin_five_uv))
        else $error("overvoltage and undervoltage together");
    chk_good_pen: assert property (supply_good_out |-> power_enable)
        else $error("good without enable");
    chk_good_first: assert property ($fell(supply_good_out) |-> power_enable [*8])
        else $error("enable fell too soon after good");
    chk_on_window: assert property ($rose(supply_good_out) |->
        cnt >= 200 * CYCLES_PER_MS - 2 && cnt <= 1600 * CYCLES_PER_MS)
        else $error("good delay out of range");
    chk_off_window: assert property ($fell(power_enable) && had_good |->
        cnt >= CYCLES_PER_MS - 2 && cnt <= 4 * CYCLES_PER_MS)
        else $error("enable off delay out of range");
endmodule : mpgt_chk
bind mpgt_top mpgt_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_mpgt_chk (.pclk, .presetn,
    .psel, .penable, .paddr, .pready, .pslverr, .monitor_pin_five, .reference_out_en,
    .pin_four_ov, .pin_four_uv, .pin_five_ov, .pin_five_uv, .supply_good_out, .power_enable);
`default_nettype wire

//--- tb/mpgt_top_tb.sv
// Purpose: Self-checking bench for mpgt_top
// Assumes: Ten cycles per millisecond shorten every delay
// Notes: All inputs change by NBA at the rising edge
`timescale 1ns/1ns
`default_nettype none
module mpgt_top_tb
    import mpgt_pkg::*;
;
    localparam int unsigned CMS = 10;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, err, a, j, em;
    logic power_on_request = 1'h0, mains_sense_one = 1'h0, mains_sense_two = 1'h0;
    logic pin_four_above_low = 1'h0, pin_four_above_mid = 1'h0, pin_four_above_high = 1'h0;
    logic pin_five_above_dac = 1'h0;
    logic monitor_pin_four, monitor_pin_five, reference_out_en, pin_four_ov, pin_four_uv;
    logic pin_five_ov, pin_five_uv, supply_good_out, mains_good_out, power_enable, irq;
    logic [31:0] rd;
    logic [2:0] e4, e5;
    int unsigned n;
    int bad_count = 0;
    int compares = 0;
    logic [5:0] tab [2:7] = '{6'h30, 6'h21, 6'h22, 6'h28, 6'h20, 6'h04};
    logic [3:0] lvls [5] = '{4'h0, 4'h1, 4'hF, 4'hB, 4'h9};
    int unsigned deb [4] = '{DEB_MS_0 * CMS, DEB_MS_1 * CMS, DEB_MS_2 * CMS, DEB_MS_3 * CMS};
    int unsigned on [4] = '{ON_MS_0 * CMS, ON_MS_1 * CMS, ON_MS_2 * CMS, ON_MS_3 * CMS};
    int unsigned off [4] = '{OFF_MS_0 * CMS, OFF_MS_1 * CMS, OFF_MS_2 * CMS, OFF_MS_3 * CMS};

    mpgt_top #(.CYCLES_PER_MS(CMS)) i_mpgt_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .power_on_request, .mains_sense_one,
        .mains_sense_two, .pin_four_above_low, .pin_four_above_mid, .pin_four_above_high,
        .pin_five_above_dac, .monitor_pin_four, .monitor_pin_five, .reference_out_en,
        .pin_four_ov, .pin_four_uv, .pin_five_ov, .pin_five_uv, .supply_good_out,
        .mains_good_out, .power_enable, .irq);

    always #5 pclk = ~pclk;

    // ****
    // Reporting and compares
    // ****
    task report_and_stop;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task fail(input string m);
        bad_count++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : fail
    task tmo;
        fail("wait ran out");
        report_and_stop();
    endtask : tmo
    task chk32(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) fail($sformatf("word %h expected %h", g, e));
    endtask : chk32
    task chk1(input logic g, input logic e);
        compares++;
        if (g !== e) fail($sformatf("bit %b expected %b", g, e));
    endtask : chk1
    task chkn(input int unsigned g, input int unsigned lo, input int unsigned hi);
        compares++;
        if (g < lo || g > hi) fail($sformatf("count %0d outside %0d..%0d", g, lo, hi));
    endtask : chkn
    // ****
    // Bus cycle and waits
    // ****
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        if (pready !== 1'h1) tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task settle;
        repeat (5) @(posedge pclk);
        #1;
    endtask : settle
    function automatic logic probe(input int s);
        return (s == 0) ? power_enable : supply_good_out;
    endfunction : probe
    task wait_lvl(input int s, input logic lvl);
        n = 0;
        while (probe(s) !== lvl && n < 20000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (probe(s) !== lvl) tmo();
    endtask : wait_lvl

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, OFS_CONFIG, 32'h0);
        chk32(rd, {17'h0, CFG_RESET});
        apb(1'h0, OFS_STATUS, 32'h0);
        chk32(rd, 32'h0);
        apb(1'h0, OFS_INT_MASK, 32'h0);
        chk32(rd, {25'h0, MASK_RESET});
        apb(1'h0, 12'h010, 32'h0);
        chk32(rd, 32'h0);
        chk1(err, 1'h1);
        apb(1'h1, OFS_CONFIG, 32'hFFFFFFFF);
        apb(1'h0, OFS_CONFIG, 32'h0);
        chk32(rd, 32'h00007FFF);
        for (int c = 2; c < 8; c++) begin
            apb(1'h1, OFS_CONFIG, 32'(c) | (32'(c) << 4));
            for (int s = 0; s < 5; s++) begin
                @(posedge pclk);
                {pin_five_above_dac, pin_four_above_high, pin_four_above_mid,
                    pin_four_above_low} <= lvls[s];
                settle();
                e4 = (s < 2 || (s == 4 && (c == 3 || c == 4))) ? tab[c][2:0] : tab[c][5:3];
                e5 = (c == 7) ? 3'h0 : ((s < 2) ? tab[c][2:0] : tab[c][5:3]);
                chk32({29'h0, monitor_pin_four, pin_four_ov, pin_four_uv}, {29'h0, e4});
                chk32({28'h0, reference_out_en, monitor_pin_five, pin_five_ov, pin_five_uv},
                    {28'h0, c == 7, e5});
            end
        end
        for (int k = 0; k < 4; k++) begin
            {a, j} = 2'(k);
            apb(1'h1, OFS_CONFIG, {23'h0, a, a, 3'(a), 1'h0, 3'(a)});
            @(posedge pclk);
            mains_sense_one <= j;
            mains_sense_two <= !j;
            settle();
            em = a ? !j : j;
            chk1(mains_good_out, em);
            chk1(monitor_pin_five, em ^ a);
            chk1(monitor_pin_four, a);
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, OFS_CONFIG, 32'(i) << 9 | 32'(i) << 11 | 32'(i) << 13);
            apb(1'h0, OFS_INT_STATUS, 32'h0);
            @(posedge pclk);
            power_on_request <= 1'h1;
            wait_lvl(0, 1'h1);
            chkn(n, deb[i], deb[i] + 5);
            wait_lvl(1, 1'h1);
            chkn(n, on[i], on[i]);
            if (i == 1) begin
                chk1(irq, 1'h0);
                apb(1'h1, OFS_INT_MASK, 32'h1);
                settle();
                chk1(irq, 1'h1);
                apb(1'h0, OFS_INT_STATUS, 32'h0);
                chk32(rd, 32'h1);
                settle();
                chk1(irq, 1'h0);
                apb(1'h0, OFS_INT_STATUS, 32'h0);
                chk32(rd, 32'h0);
            end
            @(posedge pclk);
            power_on_request <= 1'h0;
            wait_lvl(1, 1'h0);
            chkn(n, deb[i], deb[i] + 5);
            wait_lvl(0, 1'h0);
            chkn(n, off[i], off[i]);
        end
        report_and_stop();
    end
endmodule : mpgt_top_tb
`default_nettype wire
